// file: common/otgc_map.svh
`ifndef OTGC_MAP_SVH
`define OTGC_MAP_SVH

// ------------------------------
// Register offsets
// ------------------------------
`define OTGC_OFS_CTRL       6'h0a
`define OTGC_OFS_SET        6'h0b
`define OTGC_OFS_CLR        6'h0c

// ------------------------------
// Field positions
// ------------------------------
`define OTGC_BIT_IDPU       0
`define OTGC_BIT_DPPD       1
`define OTGC_BIT_DMPD       2
`define OTGC_BIT_DISCHG     3
`define OTGC_BIT_CHG        4
`define OTGC_BIT_DRV        5
`define OTGC_BIT_EXTSUP     6
`define OTGC_BIT_EXTIND     7

// ------------------------------
// Reset value
// ------------------------------
`define OTGC_CTRL_RST       8'h06

`endif

// file: common/otgc_pkg.sv
package otgc_pkg;

	// Register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} otgc_req_t;

	// Analogue front end controls
	typedef struct packed {
		logic power_switch_out;
		logic bus_power_charge;
		logic bus_power_discharge;
		logic minus_line_pulldown;
		logic plus_line_pulldown;
		logic id_strong_pullup_res;
		logic id_weak_pullup_res;
		logic id_sample_en;
	} otgc_afe_t;

	typedef enum logic [1:0] {
		OTGC_ACC_NONE,
		OTGC_ACC_WRITE,
		OTGC_ACC_SET,
		OTGC_ACC_CLR
	} otgc_acc_t;

endpackage : otgc_pkg

// file: core/otgc_sync3.sv
`timescale 1ns/1ns
// ------------------------------
// Three-stage pin synchroniser
// ------------------------------
module otgc_sync3 (
	input  wire logic i_mclk,  // Clock
	input  wire logic i_rst,   // Sync reset
	input  wire logic i_ce,    // Clock enable
	input  wire logic i_pin,   // Asynchronous pin
	output logic      o_level  // Filtered level
);
	logic [2:0] sh_q;
	logic [2:0] sh_d;
	logic       lvl_q;
	logic       lvl_d;

	always_comb begin
		sh_d  = sh_q;
		lvl_d = lvl_q;
		if (i_ce) begin
			sh_d = {sh_q[1:0], i_pin};
			// Accept once stages two and three agree
			if (sh_q[1] == sh_q[2])
				lvl_d = sh_q[2];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sh_q  <= 3'h0;
			lvl_q <= 1'b0;
		end else begin
			sh_q  <= sh_d;
			lvl_q <= lvl_d;
		end
	end

	assign o_level = lvl_q;
endmodule : otgc_sync3

// file: core/otgc_ctrl.sv
`timescale 1ns/1ns
`include "otgc_map.svh"
// Behaviour
// - ID bit 0 with weak-sample enable 1 samples ID using weak pullup, plus strong pullup when accessory detect forces it.
// - ID bit 0 keeps weak pullup on; no sampling without weak-sample enable.
// - ID bit 1 connects strong pullup and enables ID sampling.
// - Accessory detect enabled forces strong pullup in detect and setup states.
// - Set alias reads control register; ones written set bits.
// - Clear alias reads control register; ones written clear bits.
// - Zeros written to either alias leave bits unchanged.
// - Aliases own no storage; all paths see one register.
// - External indicator select uses over-current pin as bus valid.
// - Power switch asserted by external supply select or drive bit.
module otgc_ctrl
	import otgc_pkg::*;
(
	input  wire logic       i_mclk,                  // 50 MHz clock
	input  wire logic       i_rst,                   // Sync reset, active high
	input  wire logic       i_ce,                    // Clock enable
	input  wire otgc_req_t  i_req,                   // Register access
	output logic [7:0]      o_rdata,                 // Read data
	output logic            o_hit,                   // Address decoded
	input  wire logic       i_id_weak_sample_enable, // Weak sampling enable
	input  wire logic       i_accessory_detect_enable, // Accessory detect enable
	input  wire logic       i_accessory_detect_state,  // Charger machine in detect
	input  wire logic       i_accessory_setup_state,   // Charger machine in setup
	input  wire logic       i_overcurrent_pin,       // External indicator pin
	input  wire logic       i_int_vbus_valid,        // Internal comparator
	output logic            o_vbus_valid,            // Selected bus valid
	output otgc_afe_t       o_afe,                   // Front end controls
	output logic [7:0]      o_ctrl                   // Register contents
);
	// ------------------------------
	// Decode
	// ------------------------------
	otgc_acc_t  acc;
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic       ext_lvl;

	always_comb begin
		acc   = OTGC_ACC_NONE;
		o_hit = 1'b0;
		if (i_req.addr == `OTGC_OFS_CTRL) begin
			o_hit = 1'b1;
			if (i_req.wr)
				acc = OTGC_ACC_WRITE;
		end else if (i_req.addr == `OTGC_OFS_SET) begin
			o_hit = 1'b1;
			if (i_req.wr)
				acc = OTGC_ACC_SET;
		end else if (i_req.addr == `OTGC_OFS_CLR) begin
			o_hit = 1'b1;
			if (i_req.wr)
				acc = OTGC_ACC_CLR;
		end
	end

	// ------------------------------
	// Single backing register
	// ------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		if (i_ce) begin
			case (acc)
				OTGC_ACC_WRITE: ctrl_d = i_req.wdata;
				OTGC_ACC_SET:   ctrl_d = ctrl_q | i_req.wdata;
				OTGC_ACC_CLR:   ctrl_d = ctrl_q & ~i_req.wdata;
				default:        ctrl_d = ctrl_q;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			ctrl_q <= `OTGC_CTRL_RST;
		else
			ctrl_q <= ctrl_d;
	end

	// ------------------------------
	// Read data register
	// ------------------------------
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       rd_take;

	// All three offsets read the same storage
	assign rd_take = i_ce & i_req.rd;

	always_comb begin
		rdata_d = rdata_q;
		if (rd_take) begin
			if (o_hit)
				rdata_d = ctrl_q;
			else
				rdata_d = 8'h00;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	assign o_rdata = rdata_q;

	assign o_ctrl = ctrl_q;

	// ------------------------------
	// Over-current pin synchroniser
	// ------------------------------
	otgc_sync3 u_sync (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_pin   (i_overcurrent_pin),
		.o_level (ext_lvl)
	);

	// ------------------------------
	// Front end controls
	// ------------------------------
	logic       idpu;
	logic       acc_force;
	logic [2:0] idc_q;   // Strong, weak, sample
	logic [2:0] idc_d;
	logic [2:0] pwr_q;   // Switch, charge, discharge
	logic [2:0] pwr_d;
	logic [1:0] pd_q;    // Minus, plus
	logic [1:0] pd_d;
	logic       vv_q;
	logic       vv_d;

	assign idpu      = ctrl_q[`OTGC_BIT_IDPU];
	// Charger machine forces the strong pullup whatever the ID bit
	assign acc_force = i_accessory_detect_enable &
		(i_accessory_detect_state | i_accessory_setup_state);

	// ------------------------------
	// ID pullups and sampling
	// ------------------------------
	always_comb begin
		idc_d = idc_q;
		if (i_ce) begin
			idc_d[2] = idpu | acc_force;
			// Weak pullup keeps ID from floating
			idc_d[1] = ~idpu;
			idc_d[0] = idpu | i_id_weak_sample_enable;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			idc_q <= 3'h0;
		else
			idc_q <= idc_d;
	end

	// ------------------------------
	// Bus power
	// ------------------------------
	always_comb begin
		pwr_d = pwr_q;
		if (i_ce) begin
			pwr_d[2] = ctrl_q[`OTGC_BIT_EXTSUP] | ctrl_q[`OTGC_BIT_DRV];
			pwr_d[1] = ctrl_q[`OTGC_BIT_CHG];
			pwr_d[0] = ctrl_q[`OTGC_BIT_DISCHG];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			pwr_q <= 3'h0;
		else
			pwr_q <= pwr_d;
	end

	// ------------------------------
	// Line pulldowns
	// ------------------------------
	always_comb begin
		pd_d = pd_q;
		if (i_ce) begin
			pd_d[1] = ctrl_q[`OTGC_BIT_DMPD];
			pd_d[0] = ctrl_q[`OTGC_BIT_DPPD];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			pd_q <= 2'h0;
		else
			pd_q <= pd_d;
	end

	// ------------------------------
	// Bus valid source
	// ------------------------------
	always_comb begin
		vv_d = vv_q;
		if (i_ce) begin
			if (ctrl_q[`OTGC_BIT_EXTIND])
				vv_d = ext_lvl;
			else
				vv_d = i_int_vbus_valid;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			vv_q <= 1'b0;
		else
			vv_q <= vv_d;
	end

	// ------------------------------
	// Outputs
	// ------------------------------
	always_comb begin
		o_afe                      = '0;
		o_afe.power_switch_out     = pwr_q[2];
		o_afe.bus_power_charge     = pwr_q[1];
		o_afe.bus_power_discharge  = pwr_q[0];
		o_afe.minus_line_pulldown  = pd_q[1];
		o_afe.plus_line_pulldown   = pd_q[0];
		o_afe.id_strong_pullup_res = idc_q[2];
		o_afe.id_weak_pullup_res   = idc_q[1];
		o_afe.id_sample_en         = idc_q[0];
	end

	assign o_vbus_valid = vv_q;
endmodule : otgc_ctrl

// file: tb/otgc_link.sv
`timescale 1ns/1ns
module otgc_link
	import otgc_pkg::*;
(
	input  wire logic [7:0] i_rdata, // Read data
	input  wire logic       i_mclk,  // Clock
	output otgc_req_t       o_req    // Request
);
	initial o_req = '0;
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		o_req <= '{1'b1, 1'b0, a, d};
		@(posedge i_mclk);
		o_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		o_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge i_mclk);
		o_req.rd <= 1'b0;
		// Read data is registered on the taking edge
		@(posedge i_mclk);
		d = i_rdata;
	endtask : rd
endmodule : otgc_link

// file: tb/otgc_ctrl_chk.sv
`timescale 1ns/1ns
module otgc_ctrl_chk
	import otgc_pkg::*;
(
	input wire logic       i_mclk,  // Clock
	input wire logic       i_rst,   // Reset
	input wire logic       i_ce,    // Enable
	input wire otgc_req_t  i_req,   // Request
	input wire logic [7:0] o_rdata, // Read data
	input wire logic       o_hit,   // Decoded
	input wire otgc_afe_t  o_afe,   // Front end
	input wire logic [7:0] o_ctrl   // Register
);
	logic ws;
	logic wc;
	assign ws = i_req.wr & i_ce & (i_req.addr == 6'h0b);
	assign wc = i_req.wr & i_ce & (i_req.addr == 6'h0c);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	sequence s_on; $past(i_ce) && !$past(i_rst); endsequence
	property p_set; ws |=> o_ctrl == ($past(o_ctrl) | $past(i_req.wdata)); endproperty
	a_set: assert property (p_set) else $error("set alias");
	property p_clr; wc |=> o_ctrl == ($past(o_ctrl) & ~$past(i_req.wdata)); endproperty
	a_clr: assert property (p_clr) else $error("clear alias");
	property p_rd; i_req.rd && i_ce |=> o_rdata == ($past(o_hit) ? $past(o_ctrl) : 8'h00); endproperty
	a_rd: assert property (p_rd) else $error("read data");
	property p_rdhold; !(i_req.rd && i_ce) |=> $stable(o_rdata); endproperty
	a_rdhold: assert property (p_rdhold) else $error("read data moved");
	property p_hit; o_hit == (i_req.addr inside {6'h0a, 6'h0b, 6'h0c}); endproperty
	a_hit: assert property (p_hit) else $error("decode");
	property p_keep; !(i_req.wr & i_ce) |=> $stable(o_ctrl); endproperty
	a_keep: assert property (p_keep) else $error("register moved");
	property p_psw; s_on |-> o_afe.power_switch_out == $past(o_ctrl[5] | o_ctrl[6]); endproperty
	a_psw: assert property (p_psw) else $error("power switch");
	property p_pd; s_on |-> o_afe[6:3] == $past(o_ctrl[4:1]); endproperty
	a_pd: assert property (p_pd) else $error("line controls");
	property p_weak; s_on |-> o_afe.id_weak_pullup_res == !$past(o_ctrl[0]); endproperty
	a_weak: assert property (p_weak) else $error("weak pullup");
	c_set: cover property (ws);
	c_clr: cover property (wc);
	c_psw: cover property (o_afe.power_switch_out);
endmodule : otgc_ctrl_chk

// file: tb/otgc_ctrl_tb_top.sv
`timescale 1ns/1ns
module otgc_ctrl_tb_top;
	import otgc_pkg::*;
	logic       i_mclk;
	logic       i_rst;
	logic       hit;
	logic       vbv;
	logic [6:0] in;
	logic [7:0] rdata;
	logic [7:0] ctrl;
	logic [7:0] got;
	otgc_req_t  req;
	otgc_afe_t  afe;
	int         miscompares = 0;
	int         tests_run = 0;
	otgc_link i_link (.i_rdata(rdata), .i_mclk(i_mclk), .o_req(req));
	otgc_ctrl i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(in[6]), .i_req(req), .o_rdata(rdata), .o_hit(hit),
		.i_id_weak_sample_enable(in[5]), .i_accessory_detect_enable(in[4]), .i_accessory_detect_state(in[3]),
		.i_accessory_setup_state(in[2]), .i_overcurrent_pin(in[1]), .i_int_vbus_valid(in[0]),
		.o_vbus_valid(vbv), .o_afe(afe), .o_ctrl(ctrl));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			$display("Error %0t got %h exp %h", $time, g, e);
			miscompares++;
		end
	endtask : chk
	task automatic stop_test;
		$display("comparisons %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task automatic drv(input logic [6:0] v, input int n);
		@(posedge i_mclk);
		in <= v;
		repeat (n) @(posedge i_mclk);
	endtask : drv
	task automatic look(input logic [5:0] a, input logic [7:0] e);
		i_link.rd(a, got);
		@(negedge i_mclk);
		chk(got, e);
		chk(afe, {e[5] | e[6], e[4:1], e[0] | in[4] & (in[3] | in[2]), !e[0], e[0] | in[5]});
		chk({7'h00, vbv}, {7'h00, e[7] ? in[1] : in[0]});
		$display("test at %h done", a);
	endtask : look
	task automatic t(input logic [5:0] a, input logic [7:0] d, input logic [7:0] e);
		i_link.wr(a, d);
		look(a, e);
	endtask : t
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	initial begin
		#200000;
		miscompares++;
		stop_test;
	end
	initial begin
		i_rst = 1'b1;
		in = 7'h42;
		repeat (10) @(posedge i_mclk);
		i_rst <= 1'b0;
		look(6'h0a, 8'h06);
		t(6'h0b, 8'h21, 8'h27);
		t(6'h0b, 8'h00, 8'h27);
		t(6'h0c, 8'h25, 8'h02);
		t(6'h0c, 8'h00, 8'h02);
		t(6'h0b, 8'h40, 8'h42);
		t(6'h0b, 8'h08, 8'h4a);
		t(6'h0c, 8'h48, 8'h02);
		t(6'h0b, 8'h10, 8'h12);
		t(6'h0a, 8'h06, 8'h06);
		drv(7'h62, 0);
		look(6'h0c, 8'h06);
		drv(7'h5a, 0);
		look(6'h0b, 8'h06);
		drv(7'h56, 0);
		look(6'h0b, 8'h06);
		drv(7'h4e, 0);
		look(6'h0b, 8'h06);
		t(6'h0b, 8'h80, 8'h86);
		drv(7'h40, 6);
		look(6'h0a, 8'h86);
		t(6'h0c, 8'h80, 8'h06);
		drv(7'h02, 0);
		i_link.wr(6'h0b, 8'hff);
		drv(7'h42, 6);
		look(6'h0a, 8'h06);
		i_link.rd(6'h0d, got);
		chk(got, 8'h00);
		chk({7'h00, hit}, 8'h00);
		stop_test;
	end
endmodule : otgc_ctrl_tb_top
bind otgc_ctrl otgc_ctrl_chk i_chk (
	.i_mclk  (i_mclk),
	.i_rst   (i_rst),
	.i_ce    (i_ce),
	.i_req   (i_req),
	.o_rdata (o_rdata),
	.o_hit   (o_hit),
	.o_afe   (o_afe),
	.o_ctrl  (o_ctrl)
);
